/* File: common/ftd_pkg.sv */
// Purpose: shared types of the fast threshold detector
// Assumes: constants live in ftd_regs.svh
// Notes: structs carry the write strobe and the decoded settings
package ftd_pkg;

    typedef struct packed {
        logic valid;
        logic [14:0] addr;
        logic [7:0] data;
    } ftd_wr_t;

    typedef struct packed {
        logic [12:0] upper;
        logic [12:0] lower;
        logic [15:0] dwell;
    } ftd_cfg_t;

    typedef enum logic [1:0] {
        FTD_QUIET = 2'b01,
        FTD_ALARM = 2'b10
    } ftd_state_t;

endpackage

/* File: common/ftd_regs.svh */
// Purpose: addresses, field positions, reset values and counts for the threshold detector
// Assumes: 15-bit register addresses on the serial control port
// Notes: definitions only
`ifndef FTD_REGS_SVH
`define FTD_REGS_SVH

// configuration byte addresses
`define FTD_ADDR_UPPER_A 15'h0247
`define FTD_ADDR_UPPER_B 15'h0248
`define FTD_ADDR_LOWER_A 15'h0249
`define FTD_ADDR_LOWER_B 15'h024A
`define FTD_ADDR_DWELL_A 15'h024B
`define FTD_ADDR_DWELL_B 15'h024C
`define FTD_ADDR_BASE `FTD_ADDR_UPPER_A
`define FTD_NUM_CFG 6

// writable bits of each byte; threshold high bytes hold bits [12:8]
`define FTD_MASK_THR_A 8'hFF
`define FTD_MASK_THR_B 8'h1F
`define FTD_MASK_DWELL 8'hFF

// reset values
`define FTD_RST_UPPER_A 8'hFF
`define FTD_RST_UPPER_B 8'h1F
`define FTD_RST_LOWER_A 8'h00
`define FTD_RST_LOWER_B 8'h00
`define FTD_RST_DWELL_A 8'h01
`define FTD_RST_DWELL_B 8'h00

// magnitude and timing
`define FTD_MAG_MAX 13'h1FFF
`define FTD_LOWER_PIPE_LAT 16
`define FTD_DWELL_MAX 16'hFFFF

// serial frame: r/w bit, 15-bit address, 8-bit data, msb first
`define FTD_SPI_RW_BIT 15
`define FTD_SPI_INSTR_BITS 5'h10
`define FTD_SPI_LAST_BIT 5'h17
`define FTD_SPI_FRAME_BITS 5'h18

`endif

/* File: src/ftd_spi_port.sv */
// Purpose: serial control port slave, oversampled on sys_clk
// Assumes: mode 0 frames, sclk well below a quarter of sys_clk
// Notes: one byte per frame; write committed on the last rising edge
`timescale 1ns/1ps
`include "ftd_regs.svh"

module ftd_spi_port
    import ftd_pkg::*;
(
    input wire logic sys_clk, // sample clock
    input wire logic reset_n, // async reset, active low
    input wire logic spi_sclk, // serial clock pin
    input wire logic spi_csb_n, // chip select pin, active low
    input wire logic spi_sdi, // serial data in pin
    input wire logic [7:0] rd_data, // read byte for rd_addr
    output ftd_wr_t wr, // one-cycle write strobe
    output logic [14:0] rd_addr, // address of the frame in progress
    output logic spi_sdo, // serial data out
    output logic spi_sdo_oe_n // low while driving spi_sdo
);

    logic sclk_s1, sclk_s2, sclk_s3;
    logic csb_s1, csb_s2;
    logic sdi_s1, sdi_s2;
    logic [4:0] bit_cnt;
    logic [15:0] instr;
    logic [6:0] data_in;
    logic [7:0] sdo_shift;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; edges taken from the second stage onward only
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            csb_s1 <= 1'b1;
            csb_s2 <= 1'b1;
            sdi_s1 <= 1'b0;
            sdi_s2 <= 1'b0;
        end
        else
        begin
            sclk_s1 <= spi_sclk;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            csb_s1 <= spi_csb_n;
            csb_s2 <= csb_s1;
            sdi_s1 <= spi_sdi;
            sdi_s2 <= sdi_s1;
        end
    end

    wire logic sclk_rise = sclk_s2 & ~sclk_s3;
    wire logic sclk_fall = ~sclk_s2 & sclk_s3;
    wire logic in_instr = bit_cnt < `FTD_SPI_INSTR_BITS;
    wire logic is_read = instr[`FTD_SPI_RW_BIT];
    wire logic last_rise = sclk_rise && (bit_cnt == `FTD_SPI_LAST_BIT) && !is_read;
    wire logic load_sdo = sclk_fall && (bit_cnt == `FTD_SPI_INSTR_BITS) && is_read;
    wire logic shift_sdo = sclk_fall && (bit_cnt > `FTD_SPI_INSTR_BITS) && is_read;

    assign rd_addr = instr[14:0];

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bit_cnt <= 5'h00;
            instr <= 16'h0000;
            data_in <= 7'h00;
            wr <= '0;
        end
        else if (csb_s2)
        begin
            bit_cnt <= 5'h00;
            wr <= '0;
        end
        else
        begin
            wr.valid <= last_rise;
            wr.addr <= instr[14:0];
            wr.data <= {data_in, sdi_s2};
            if (sclk_rise && in_instr)
            begin
                instr <= {instr[14:0], sdi_s2};
            end
            if (sclk_rise && !in_instr)
            begin
                data_in <= {data_in[5:0], sdi_s2};
            end
            // extra clocks after a full frame are ignored
            if (sclk_rise && (bit_cnt < `FTD_SPI_FRAME_BITS))
            begin
                bit_cnt <= bit_cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sdo_shift <= 8'h00;
            spi_sdo <= 1'b0;
            spi_sdo_oe_n <= 1'b1;
        end
        else if (csb_s2)
        begin
            spi_sdo <= 1'b0;
            spi_sdo_oe_n <= 1'b1;
        end
        else if (load_sdo)
        begin
            sdo_shift <= {rd_data[6:0], 1'b0};
            spi_sdo <= rd_data[7];
            spi_sdo_oe_n <= 1'b0;
        end
        else if (shift_sdo)
        begin
            sdo_shift <= {sdo_shift[6:0], 1'b0};
            spi_sdo <= sdo_shift[7];
        end
    end

endmodule // ftd_spi_port

/* File: src/ftd_top.sv */
// Purpose: fast threshold detector with hysteresis on the converter output magnitude
// Assumes: adc_sample is 14-bit two's complement on sys_clk, one sample per clock
// Notes: configuration reached only over the serial control port
// Behaviour
// - the alarm flag is raised at once when a sample magnitude exceeds the upper threshold.
// - the flag drops only after magnitudes stay below the lower threshold longer than the dwell.
// - the upper comparison raises the flag within 28 clocks of the offending sample.
// - the upper threshold comes from the bytes at upper_threshold_byte_a and upper_threshold_byte_b and meets the output magnitude.
// - the lower threshold comes from the bytes at lower_threshold_byte_a and lower_threshold_byte_b.
// - the lower threshold is a 13-bit value compared at full converter resolution.
// - the lower comparison uses samples delayed by the normal pipeline latency.
// - thresholds are scaled so that two to the thirteenth is full-scale magnitude.
// - the 16-bit dwell count comes from the bytes at dwell_count_byte_a and dwell_count_byte_b.
`timescale 1ns/1ps
`include "ftd_regs.svh"

module ftd_top
    import ftd_pkg::*;
(
    input wire logic sys_clk, // sample clock, 125 MHz
    input wire logic reset_n, // async reset, active low
    input wire logic [13:0] adc_sample, // converter output, two's complement
    input wire logic spi_sclk, // serial control clock pin
    input wire logic spi_csb_n, // serial control select pin
    input wire logic spi_sdi, // serial control data in pin
    output logic threshold_alarm_flag, // alarm flag to gain control
    output logic spi_sdo, // serial control data out
    output logic spi_sdo_oe_n // low while spi_sdo is driven
);

    localparam int NUM_CFG = `FTD_NUM_CFG;
    localparam int PIPE_LAT = `FTD_LOWER_PIPE_LAT;
    localparam logic [4:0] SETTLE_LOAD = 5'(PIPE_LAT - 1);

    localparam logic [7:0] CFG_RST [NUM_CFG] = '{
        `FTD_RST_UPPER_A, `FTD_RST_UPPER_B,
        `FTD_RST_LOWER_A, `FTD_RST_LOWER_B,
        `FTD_RST_DWELL_A, `FTD_RST_DWELL_B
    };
    localparam logic [7:0] CFG_MASK [NUM_CFG] = '{
        `FTD_MASK_THR_A, `FTD_MASK_THR_B,
        `FTD_MASK_THR_A, `FTD_MASK_THR_B,
        `FTD_MASK_DWELL, `FTD_MASK_DWELL
    };

    ftd_wr_t spi_wr;
    ftd_cfg_t cfg;
    ftd_state_t state;
    ftd_state_t next_state;
    logic [14:0] rd_addr;
    logic [7:0] rd_data;
    logic [7:0] cfg_byte [NUM_CFG];
    logic [NUM_CFG-1:0] cfg_hit;
    logic [12:0] mag;
    logic [12:0] lower_pipe [PIPE_LAT];
    logic [15:0] dwell_cnt;
    logic [15:0] next_dwell_cnt;
    logic next_flag;
    logic [4:0] settle_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // serial control port
    ftd_spi_port u_spi_port (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .spi_sclk(spi_sclk),
        .spi_csb_n(spi_csb_n),
        .spi_sdi(spi_sdi),
        .rd_data(rd_data),
        .wr(spi_wr),
        .rd_addr(rd_addr),
        .spi_sdo(spi_sdo),
        .spi_sdo_oe_n(spi_sdo_oe_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    // configuration bytes; the six addresses are contiguous
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CFG; gi++)
        begin : g_cfg
            assign cfg_hit[gi] = spi_wr.valid &&
                (spi_wr.addr == `FTD_ADDR_BASE + 15'(gi));
            // new values take effect from the next sample on
            always_ff @(posedge sys_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    cfg_byte[gi] <= CFG_RST[gi];
                end
                else if (cfg_hit[gi])
                begin
                    cfg_byte[gi] <= spi_wr.data & CFG_MASK[gi];
                end
            end
        end
    endgenerate

    wire logic [7:0] upper_threshold_byte_a = cfg_byte[0];
    wire logic [7:0] upper_threshold_byte_b = cfg_byte[1];
    wire logic [7:0] lower_threshold_byte_a = cfg_byte[2];
    wire logic [7:0] lower_threshold_byte_b = cfg_byte[3];
    wire logic [7:0] dwell_count_byte_a = cfg_byte[4];
    wire logic [7:0] dwell_count_byte_b = cfg_byte[5];

    assign cfg.upper = {upper_threshold_byte_b[4:0], upper_threshold_byte_a};
    assign cfg.lower = {lower_threshold_byte_b[4:0], lower_threshold_byte_a};
    assign cfg.dwell = {dwell_count_byte_b, dwell_count_byte_a};

    // read back; unmapped addresses answer zero, reserved bits read zero
    wire logic [14:0] rd_offset = rd_addr - `FTD_ADDR_BASE;
    wire logic rd_mapped = (rd_addr >= `FTD_ADDR_BASE) &&
        (rd_offset < 15'(NUM_CFG));
    wire logic [2:0] rd_index = rd_offset[2:0];
    assign rd_data = rd_mapped ? cfg_byte[rd_index] : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // 13-bit magnitude; the single code -8192 saturates to full scale
    wire logic [13:0] neg_sample = 14'h0000 - adc_sample;
    wire logic [13:0] abs_sample = adc_sample[13] ? neg_sample : adc_sample;
    wire logic [12:0] next_mag = abs_sample[13] ? `FTD_MAG_MAX : abs_sample[12:0];

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mag <= 13'h0000;
        end
        else
        begin
            mag <= next_mag;
        end
    end

    // fast path: compare straight after the magnitude register
    wire logic upper_hit = mag > cfg.upper;

    ////////////////////////////////////////////////////////////////////////////
    // slow path: magnitude delayed by the normal pipeline latency
    generate
        for (gi = 0; gi < PIPE_LAT; gi++)
        begin : g_pipe
            always_ff @(posedge sys_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    lower_pipe[gi] <= 13'h0000;
                end
                else if (gi == 0)
                begin
                    lower_pipe[gi] <= mag;
                end
                else
                begin
                    lower_pipe[gi] <= lower_pipe[(gi == 0) ? 0 : gi - 1];
                end
            end
        end
    endgenerate

    wire logic [12:0] lower_mag = lower_pipe[PIPE_LAT-1];
    wire logic below_lower = lower_mag < cfg.lower;
    // run of dwell+1 samples is needed, so a dwell of n means longer than n
    wire logic dwell_done = dwell_cnt >= cfg.dwell;
    // slow path still holds samples older than a fresh hit; they must not count
    wire logic settle_busy = settle_cnt != 5'h00;
    wire logic [4:0] next_settle_cnt = upper_hit ? SETTLE_LOAD
        : (settle_busy ? settle_cnt - 5'h01 : 5'h00);

    ////////////////////////////////////////////////////////////////////////////
    // flag state; an upper hit always wins over a pending release
    always_comb
    begin
        next_state = state;
        next_dwell_cnt = dwell_cnt;
        case (state)
            FTD_QUIET:
            begin
                next_dwell_cnt = 16'h0000;
                if (upper_hit)
                begin
                    next_state = FTD_ALARM;
                end
            end
            FTD_ALARM:
            begin
                if (upper_hit || !below_lower || settle_busy)
                begin
                    next_dwell_cnt = 16'h0000;
                end
                else if (dwell_done)
                begin
                    next_state = FTD_QUIET;
                    next_dwell_cnt = 16'h0000;
                end
                else
                begin
                    next_dwell_cnt = dwell_cnt + 16'h0001;
                end
            end
            default:
            begin
                next_state = FTD_QUIET;
                next_dwell_cnt = 16'h0000;
            end
        endcase
    end

    assign next_flag = (next_state == FTD_ALARM);

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= FTD_QUIET;
            dwell_cnt <= 16'h0000;
            settle_cnt <= 5'h00;
            threshold_alarm_flag <= 1'b0;
        end
        else
        begin
            state <= next_state;
            dwell_cnt <= next_dwell_cnt;
            settle_cnt <= next_settle_cnt;
            threshold_alarm_flag <= next_flag;
        end
    end

endmodule // ftd_top

/* File: tb/ftd_agc_model.sv */
// Purpose: gain control stand-in watching the alarm flag
// Assumes: flag is a registered level on sys_clk
// Notes: a real loop steps gain down per episode; this one only counts them
`timescale 1ns/1ps

module ftd_agc_model
(
    input wire logic sys_clk, // sample clock
    input wire logic reset_n, // async reset, active low
    input wire logic threshold_alarm_flag, // alarm from the detector
    output logic [7:0] gain_steps // gain reductions taken
);
    logic flag_q;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flag_q <= 1'b0;
            gain_steps <= 8'h00;
        end
        else
        begin
            flag_q <= threshold_alarm_flag;
            if (threshold_alarm_flag && !flag_q)
                gain_steps <= gain_steps + 8'h01;
        end
    end
endmodule // ftd_agc_model

/* File: tb/ftd_top_asserts.sv */
// Purpose: port-level checks of the threshold detector
// Assumes: settings are shadowed from write frames seen on the serial pins
// Notes: shadow commits when select rises, so bench must not sample while writing
`timescale 1ns/1ps
`include "ftd_regs.svh"

module ftd_top_asserts
    import ftd_pkg::*;
(
    input wire logic sys_clk, // sample clock
    input wire logic reset_n, // async reset, active low
    input wire logic [13:0] adc_sample, // converter sample
    input wire logic spi_sclk, // serial clock pin
    input wire logic spi_csb_n, // serial select pin
    input wire logic spi_sdi, // serial data in pin
    input wire logic threshold_alarm_flag, // alarm flag
    input wire logic spi_sdo, // serial data out
    input wire logic spi_sdo_oe_n // sdo enable, low drives
);
    logic [23:0] frame;
    logic [4:0] nbits;
    ftd_cfg_t cfg;
    logic [16:0] in_below;
    logic [13:0] neg;
    logic [12:0] mag;
    logic hit_upper;
    logic [16:0] since_hit;

    assign neg = -adc_sample;
    assign mag = (adc_sample == 14'h2000) ? 13'h1FFF
        : (adc_sample[13] ? neg[12:0] : adc_sample[12:0]);
    assign hit_upper = mag > cfg.upper;

    always_ff @(posedge spi_sclk or posedge spi_csb_n)
    begin
        if (spi_csb_n)
            nbits <= 5'h00;
        else
        begin
            frame <= {frame[22:0], spi_sdi};
            nbits <= nbits + 5'h01;
        end
    end

    always_ff @(posedge spi_csb_n or negedge reset_n)
    begin
        if (!reset_n)
            cfg <= '{upper: 13'h1FFF, lower: 13'h0000, dwell: 16'h0001};
        else if (nbits == 5'h18 && !frame[23])
        begin
            case (frame[22:8])
                `FTD_ADDR_UPPER_A: cfg.upper[7:0] <= frame[7:0];
                `FTD_ADDR_UPPER_B: cfg.upper[12:8] <= frame[4:0];
                `FTD_ADDR_LOWER_A: cfg.lower[7:0] <= frame[7:0];
                `FTD_ADDR_LOWER_B: cfg.lower[12:8] <= frame[4:0];
                `FTD_ADDR_DWELL_A: cfg.dwell[7:0] <= frame[7:0];
                `FTD_ADDR_DWELL_B: cfg.dwell[15:8] <= frame[7:0];
                default: ;
            endcase
        end
    end

    // run of input samples below lower, counted before the slow-path delay
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            in_below <= 17'h00000;
        else
            in_below <= (mag < cfg.lower) ? in_below + 17'h00001 : 17'h00000;
    end

    // samples since the last upper hit, saturating
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            since_hit <= 17'h00000;
        else if (hit_upper)
            since_hit <= 17'h00000;
        else if (since_hit != 17'h1FFFF)
            since_hit <= since_hit + 17'h00001;
    end

    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_raise;
        hit_upper ##2 threshold_alarm_flag;
    endsequence

    AST_UPPER_RAISE: assert property (hit_upper |-> s_raise)
        else $error("flag not raised two clocks after an upper hit");
    AST_RISE_CAUSE: assert property ($rose(threshold_alarm_flag) |-> $past(hit_upper, 2))
        else $error("flag rose without an upper hit");
    AST_RELEASE_RUN: assert property ($fell(threshold_alarm_flag) |-> $past(in_below, 17) > cfg.dwell)
        else $error("flag fell before a full below run");
    AST_RELEASE_AFTER_HIT: assert property ($fell(threshold_alarm_flag) |-> since_hit > {1'b0, cfg.dwell} + 17'h00011)
        else $error("flag fell before the slow path passed the last hit");
    AST_RESET_QUIET: assert property ($rose(reset_n) |-> !threshold_alarm_flag && spi_sdo_oe_n)
        else $error("outputs active right after reset");
    AST_SDO_QUIET: assert property (spi_sdo_oe_n |-> !spi_sdo)
        else $error("sdo high while not driven");
    AST_OE_RELEASE: assert property ($rose(spi_csb_n) |-> ##[1:6] spi_sdo_oe_n)
        else $error("sdo still driven after select rose");
    AST_OE_IN_FRAME: assert property (!spi_sdo_oe_n |-> !$past(spi_csb_n, 6))
        else $error("sdo driven outside a frame");
    AST_FRAME_START: assert property ($fell(spi_csb_n) |-> spi_sdo_oe_n [*8])
        else $error("sdo driven at frame start");
endmodule // ftd_top_asserts

bind ftd_top ftd_top_asserts u_asserts (.sys_clk(sys_clk), .reset_n(reset_n),
    .adc_sample(adc_sample), .spi_sclk(spi_sclk), .spi_csb_n(spi_csb_n),
    .spi_sdi(spi_sdi), .threshold_alarm_flag(threshold_alarm_flag),
    .spi_sdo(spi_sdo), .spi_sdo_oe_n(spi_sdo_oe_n));

/* File: tb/tb_top.sv */
// Purpose: register and sample-path regression of the threshold detector
// Assumes: serial clock at one eleventh of sys_clk, slow enough for the pin syncs
// Notes: release timing is checked to the exact sample
`timescale 1ns/1ps
`include "ftd_regs.svh"

module tb_top;
    logic sys_clk = 1'b0;
    logic reset_n;
    logic [13:0] adc_sample = 14'h0000;
    logic spi_sclk = 1'b0;
    logic spi_csb_n;
    logic spi_sdi = 1'b0;
    logic threshold_alarm_flag;
    logic spi_sdo;
    logic spi_sdo_oe_n;
    logic [7:0] gain_steps;
    logic [7:0] rd;
    logic oe_rd;
    int fails = 0;
    int check_count = 0;
    int rise;
    int fall;
    logic [14:0] addrs [7] = '{`FTD_ADDR_UPPER_A, `FTD_ADDR_UPPER_B, `FTD_ADDR_LOWER_A,
        `FTD_ADDR_LOWER_B, `FTD_ADDR_DWELL_A, `FTD_ADDR_DWELL_B, 15'h024D};
    logic [7:0] rst_vals [7] = '{8'hFF, 8'h1F, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
    logic [7:0] wr_vals [7] = '{8'hFF, 8'hEF, 8'h1D, 8'hEA, 8'h03, 8'h00, 8'h5A};
    logic [7:0] rb_vals [7] = '{8'hFF, 8'h0F, 8'h1D, 8'h0A, 8'h03, 8'h00, 8'h00};

    always #4 sys_clk = ~sys_clk;

    ftd_top dut (.sys_clk(sys_clk), .reset_n(reset_n), .adc_sample(adc_sample),
        .spi_sclk(spi_sclk), .spi_csb_n(spi_csb_n), .spi_sdi(spi_sdi),
        .threshold_alarm_flag(threshold_alarm_flag), .spi_sdo(spi_sdo),
        .spi_sdo_oe_n(spi_sdo_oe_n));
    ftd_agc_model agc (.sys_clk(sys_clk), .reset_n(reset_n),
        .threshold_alarm_flag(threshold_alarm_flag), .gain_steps(gain_steps));

    ////////////////////////////////////////////////////////////
    task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_flag(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    // one byte per frame; read bits taken just before each rising sclk
    task automatic xfer(input logic rw, input logic [14:0] addr, input logic [7:0] wdata);
        logic [23:0] f;
        f = {rw, addr, wdata};
        @(posedge sys_clk);
        spi_csb_n <= 1'b0;
        for (int b = 23; b >= 0; b--)
        begin
            spi_sdi <= f[b];
            repeat (6) @(posedge sys_clk);
            if (b < 8)
                rd[b] = spi_sdo;
            if (b == 0)
                oe_rd = spi_sdo_oe_n;
            spi_sclk <= 1'b1;
            repeat (5) @(posedge sys_clk);
            spi_sclk <= 1'b0;
        end
        repeat (8) @(posedge sys_clk);
        spi_csb_n <= 1'b1;
        repeat (16) @(posedge sys_clk);
    endtask

    task automatic step(input logic [13:0] v);
        @(posedge sys_clk);
        adc_sample <= v;
        @(negedge sys_clk);
    endtask

    // hit, then zeros with an at-lower sample every third clock up to gap
    task automatic episode(input logic [15:0] dw, input int gap);
        xfer(1'b0, `FTD_ADDR_DWELL_A, dw[7:0]);
        xfer(1'b0, `FTD_ADDR_DWELL_B, dw[15:8]);
        step(14'h3000);
        rise = 0;
        fall = 0;
        for (int n = 1; n < 400 && fall == 0; n++)
        begin
            step((n <= gap && n % 3 == 0) ? 14'h0A1D : 14'h0000);
            if (threshold_alarm_flag === 1'b1 && rise == 0)
                rise = n;
            if (threshold_alarm_flag === 1'b0 && rise != 0)
                fall = n;
        end
        cmp_flag("rise delay", 1'b1, rise > 0 && rise <= 28);
        cmp_flag("release time", 1'b1, fall == gap + dw + 19);
        $display("test episode dwell %0d gap %0d done", dw, gap);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial
    begin
        // time-zero edges so async resets and the checker's frame counter start clean
        reset_n <= 1'b0;
        spi_csb_n <= 1'b1;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        for (int k = 0; k < 7; k++)
        begin
            xfer(1'b1, addrs[k], 8'h00);
            cmp_byte("reset value", rst_vals[k], rd);
            cmp_flag("sdo enable in read", 1'b0, oe_rd);
        end
        cmp_flag("sdo enable idle", 1'b1, spi_sdo_oe_n);
        repeat (30) step(14'h2000);
        cmp_flag("flag at full scale", 1'b0, threshold_alarm_flag);
        // silence first, so the lowered upper threshold cannot raise the flag mid-write
        step(14'h0000);
        $display("test reset values done");
        for (int k = 0; k < 7; k++)
            xfer(1'b0, addrs[k], wr_vals[k]);
        for (int k = 0; k < 7; k++)
        begin
            xfer(1'b1, addrs[k], 8'h00);
            cmp_byte("read back", rb_vals[k], rd);
        end
        $display("test write and read back done");
        for (int n = 0; n < 30; n++)
            step(n % 2 ? 14'h0FFF : 14'h3001);
        cmp_flag("flag at equal upper", 1'b0, threshold_alarm_flag);
        $display("test upper boundary done");
        episode(16'h0003, 0);
        episode(16'h0003, 45);
        episode(16'h0001, 0);
        episode(16'h0100, 0);
        cmp_byte("alarm episodes", 8'h04, gain_steps);
        conclude();
    end

    initial
    begin
        repeat (40000) @(posedge sys_clk);
        fails++;
        conclude();
    end
endmodule // tb_top
